// >>> hdl/host_bus_cycle_interface.sv
// Host bus master write, arbitration and slave access logic
`timescale 1ns/1ps
`include "host_bus_defs.svh"
module host_bus_cycle_interface #(
   parameter int DATA_W = `DATA_W,
   parameter int ADDR_W = 32,
   parameter int SLV_AW = 7,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [1:0] wr_size,
   input wire logic burst_enable,
   input wire logic fetch_req,
   input wire logic fetch_done,
   input wire logic fatal_error,
   input wire logic scsi_irq,
   output logic irq,
   input wire logic [7:0] dma_control_reg,
   input wire logic [7:0] test_reg_three,
   input wire logic snoop_ctrl0,
   input wire logic grant_bus_n,
   input wire logic busy_bus_n_i,
   output logic busy_bus_n_o,
   output logic busy_bus_n_oe,
   output logic req_bus_n,
   output logic owner_active_n,
   output logic grant_ack_n,
   output logic instr_load_n,
   output logic ctrl_oe,
   output logic addr_strobe_n,
   output logic data_strobe_n,
   output logic line_burst_request_n,
   input wire logic line_burst_ack_n,
   input wire logic sync_termination_n,
   input wire logic bus_fault_n,
   input wire logic stop_retry_n,
   output logic [ADDR_W-1:0] addr_o,
   output logic addr_oe,
   output logic [1:0] xfer_size,
   output logic [DATA_W-1:0] data_o,
   output logic data_oe,
   input wire logic [DATA_W-1:0] data_i,
   input wire logic chip_select_n,
   input wire logic transfer_start_n,
   input wire logic read_write_n,
   input wire logic [SLV_AW-1:0] slv_addr,
   input wire logic slv_error,
   input wire logic transfer_ack_n,
   output logic burst_inhibit_n,
   output logic target_ack_n,
   output logic transfer_error_n,
   output logic slv_oe,
   output logic [SLV_AW-1:0] reg_addr,
   output logic reg_wr,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata
);
   // Pin synchronisers: first stage read only by second stage
   localparam int NS = 10;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   logic [DATA_W-1:0] d1_q;
   logic [DATA_W-1:0] d2_q;
   always_ff @(posedge sys_clk) begin
      s1_q <= {snoop_ctrl0, grant_bus_n, busy_bus_n_i, line_burst_ack_n,
               sync_termination_n, bus_fault_n, stop_retry_n, chip_select_n,
               transfer_start_n, transfer_ack_n};
      s2_q <= s1_q;
      d1_q <= data_i;
      d2_q <= d1_q;
   end
   logic snp_s, gnt_n_s, bb_n_s, line_burst_ack_n_n_s, sync_termination_n_n_s, bus_fault_n_n_s, halt_n_s;
   logic cs_n_s, ts_n_s, ta_n_s;
   assign {snp_s, gnt_n_s, bb_n_s, line_burst_ack_n_n_s, sync_termination_n_n_s, bus_fault_n_n_s, halt_n_s,
           cs_n_s, ts_n_s, ta_n_s} = s2_q;
   logic snp_d1_q;
   always_ff @(posedge sys_clk) begin
      snp_d1_q <= !rstn ? 1'b0 : snp_s;
   end

   // Outgoing write words buffered ahead of the master engine
   localparam int PW = DATA_W + ADDR_W + 2;
   logic f_valid;
   logic f_pop;
   logic [PW-1:0] f_data;
   word_fifo #(.WIDTH(PW), .DEPTH(DEPTH)) u_fifo (
      .clk(sys_clk),
      .rstn(rstn),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data({wr_data, wr_addr, wr_size}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // Master write and arbitration engine
   host_bus_pkg::mst_e m_q;
   logic dly_q;
   logic burst_q;
   logic want;
   logic snoop_trig;
   assign snoop_trig = test_reg_three[`SNOOP_EN_BIT] && snp_s && !snp_d1_q;
   assign want = f_valid || fetch_req || snoop_trig;
   logic term_ok;
   logic term_retry;
   logic term_fault;
   assign term_retry = !bus_fault_n_n_s && !halt_n_s;
   assign term_fault = !bus_fault_n_n_s && halt_n_s;
   assign term_ok = !sync_termination_n_n_s && bus_fault_n_n_s && halt_n_s;
   assign f_pop = (m_q == host_bus_pkg::M_TERM) && term_ok;
   // Occupancy mirror tells the engine whether the word on the bus is the last one
   localparam int OW = $clog2(DEPTH) + 1;
   logic [OW-1:0] occ_q;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         occ_q <= '0;
      end else begin
         occ_q <= occ_q + OW'(wr_valid && wr_ready) - OW'(f_pop);
      end
   end
   logic last_word;
   assign last_word = occ_q == OW'(1);
   host_bus_pkg::slv_e s_q;
   logic [1:0] s_cnt_q;
   logic s_rd_q;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         m_q <= host_bus_pkg::M_IDLE;
         dly_q <= 1'b0;
         burst_q <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq <= 1'b0;
         case (m_q)
            host_bus_pkg::M_IDLE: begin
               dly_q <= 1'b0;
               if (want) begin
                  m_q <= host_bus_pkg::M_REQ;
               end
            end
            host_bus_pkg::M_REQ: begin
               dly_q <= `REQ_DELAY;
               if (dly_q) begin
                  m_q <= host_bus_pkg::M_WAITG;
               end
            end
            host_bus_pkg::M_WAITG: begin
               if (!gnt_n_s && (bb_n_s || dma_control_reg[`QUICK_ARB_BIT])) begin
                  m_q <= scsi_irq ? host_bus_pkg::M_ABORT : host_bus_pkg::M_ADDR;
               end
            end
            host_bus_pkg::M_ABORT: begin
               irq <= 1'b1;
               m_q <= host_bus_pkg::M_IDLE;
            end
            host_bus_pkg::M_ADDR: begin
               m_q <= f_valid ? host_bus_pkg::M_STRB : host_bus_pkg::M_REL;
            end
            host_bus_pkg::M_STRB: begin
               m_q <= host_bus_pkg::M_DSTB;
            end
            host_bus_pkg::M_DSTB: begin
               m_q <= host_bus_pkg::M_TERM;
            end
            host_bus_pkg::M_TERM: begin
               if (!line_burst_ack_n_n_s && burst_enable) begin
                  burst_q <= 1'b1;
               end
               if (term_retry) begin
                  m_q <= host_bus_pkg::M_ADDR;
               end else if (term_fault) begin
                  m_q <= host_bus_pkg::M_REL;
               end else if (term_ok) begin
                  if (burst_q && !last_word) begin
                     m_q <= host_bus_pkg::M_DSTB;
                  end else begin
                     m_q <= last_word ? host_bus_pkg::M_REL : host_bus_pkg::M_ADDR;
                     burst_q <= 1'b0;
                  end
               end
            end
            host_bus_pkg::M_REL: begin
               burst_q <= 1'b0;
               m_q <= host_bus_pkg::M_IDLE;
            end
            default: m_q <= host_bus_pkg::M_IDLE;
         endcase
      end
   end

   // Output registers
   logic own;
   assign own = (m_q == host_bus_pkg::M_ADDR) || (m_q == host_bus_pkg::M_STRB) ||
                (m_q == host_bus_pkg::M_DSTB) || (m_q == host_bus_pkg::M_TERM);
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         req_bus_n <= 1'b1;
         owner_active_n <= 1'b1;
         grant_ack_n <= 1'b1;
         busy_bus_n_o <= 1'b1;
         busy_bus_n_oe <= 1'b0;
         ctrl_oe <= 1'b0;
      end else begin
         req_bus_n <= !((m_q == host_bus_pkg::M_REQ && dly_q) ||
                        (m_q == host_bus_pkg::M_WAITG && gnt_n_s));
         owner_active_n <= !(own || m_q == host_bus_pkg::M_ABORT && 1'b0 ||
                             (m_q == host_bus_pkg::M_WAITG && !gnt_n_s));
         grant_ack_n <= !(own || (m_q == host_bus_pkg::M_WAITG && !gnt_n_s));
         busy_bus_n_o <= !(own || (m_q == host_bus_pkg::M_WAITG && !gnt_n_s));
         busy_bus_n_oe <= own || (m_q == host_bus_pkg::M_WAITG && !gnt_n_s);
         ctrl_oe <= own;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         addr_strobe_n <= 1'b1;
         data_strobe_n <= 1'b1;
         line_burst_request_n <= 1'b1;
         addr_o <= '0;
         xfer_size <= '0;
         data_o <= '0;
         addr_oe <= 1'b0;
      end else begin
         if (m_q == host_bus_pkg::M_ADDR && f_valid) begin
            {data_o, addr_o, xfer_size} <= f_data;
         end else if (m_q == host_bus_pkg::M_DSTB && burst_q) begin
            {data_o, addr_o, xfer_size} <= f_data;
         end else if (s_q == host_bus_pkg::S_WAIT && s_rd_q && s_cnt_q == 2'd1) begin
            data_o <= reg_rdata;
         end
         addr_oe <= own && f_valid;
         if (m_q == host_bus_pkg::M_STRB) begin
            addr_strobe_n <= 1'b0;
            line_burst_request_n <= !burst_enable;
         end else if (m_q == host_bus_pkg::M_REL || m_q == host_bus_pkg::M_ADDR) begin
            addr_strobe_n <= 1'b1;
            line_burst_request_n <= 1'b1;
         end
         data_strobe_n <= !(m_q == host_bus_pkg::M_DSTB || m_q == host_bus_pkg::M_TERM &&
                            !(term_ok || term_retry || term_fault));
      end
   end

   // Instruction fetch indicator
   logic fetch_hold_q;
   logic bb_d1_q;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         instr_load_n <= 1'b1;
         fetch_hold_q <= 1'b0;
         bb_d1_q <= 1'b1;
      end else begin
         bb_d1_q <= bb_n_s;
         if (m_q == host_bus_pkg::M_IDLE && fetch_req) begin
            instr_load_n <= 1'b0;
            fetch_hold_q <= 1'b1;
         end else if (fetch_hold_q && (fetch_done || fatal_error)) begin
            fetch_hold_q <= 1'b0;
         end else if (!fetch_hold_q && bb_n_s && !bb_d1_q) begin
            instr_load_n <= 1'b1;
         end else if (!fetch_hold_q && m_q == host_bus_pkg::M_IDLE) begin
            instr_load_n <= 1'b1;
         end
      end
   end

   // Slave access engine
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         s_q <= host_bus_pkg::S_IDLE;
         s_cnt_q <= '0;
         s_rd_q <= 1'b0;
         reg_addr <= '0;
         reg_wr <= 1'b0;
         reg_wdata <= '0;
      end else begin
         reg_wr <= 1'b0;
         case (s_q)
            host_bus_pkg::S_IDLE: begin
               if (!ts_n_s && !cs_n_s) begin
                  s_q <= host_bus_pkg::S_WAIT;
                  s_cnt_q <= `WAIT_STATES;
                  s_rd_q <= read_write_n;
                  reg_addr <= slv_addr;
               end
            end
            host_bus_pkg::S_WAIT: begin
               s_cnt_q <= s_cnt_q - 2'd1;
               if (s_cnt_q == 2'd1) begin
                  if (slv_error) begin
                     s_q <= host_bus_pkg::S_ERR;
                  end else begin
                     s_q <= host_bus_pkg::S_ACK;
                     reg_wr <= !s_rd_q;
                     reg_wdata <= d2_q;
                  end
               end
            end
            host_bus_pkg::S_ACK: begin
               if (!ta_n_s) begin
                  s_q <= host_bus_pkg::S_END;
               end
            end
            host_bus_pkg::S_ERR: s_q <= host_bus_pkg::S_END;
            host_bus_pkg::S_END: s_q <= host_bus_pkg::S_IDLE;
            default: s_q <= host_bus_pkg::S_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         burst_inhibit_n <= 1'b1;
         target_ack_n <= 1'b1;
         transfer_error_n <= 1'b1;
         slv_oe <= 1'b0;
         data_oe <= 1'b0;
      end else begin
         burst_inhibit_n <= !(s_q == host_bus_pkg::S_WAIT || s_q == host_bus_pkg::S_ACK ||
                              s_q == host_bus_pkg::S_ERR);
         target_ack_n <= !(s_q == host_bus_pkg::S_WAIT && s_cnt_q == 2'd1 && !slv_error ||
                           s_q == host_bus_pkg::S_ACK && ta_n_s);
         transfer_error_n <= !(s_q == host_bus_pkg::S_WAIT && s_cnt_q == 2'd1 &&
                               slv_error);
         slv_oe <= s_q != host_bus_pkg::S_IDLE && s_q != host_bus_pkg::S_END;
         data_oe <= (own && f_valid) ||
                    (s_rd_q && (s_q == host_bus_pkg::S_ACK ||
                     s_q == host_bus_pkg::S_WAIT && s_cnt_q == 2'd1));
      end
   end
endmodule

// >>> hdl/host_bus_defs.svh
// Constants for the host bus cycle interface
`ifndef HOST_BUS_DEFS_SVH
`define HOST_BUS_DEFS_SVH
// Overview of operation
// - Master write drives address, size and write data after owning the bus.
// - Address strobe with burst request first, then data strobe.
// - Wait for termination, burst ack, fault, halt; burst only when acknowledged.
// - Fault together with stop/retry makes the device repeat the cycle.
// - Clean termination with more words pending restarts with new address and data.
// - Last acknowledged cycle drops owner and grant acknowledge.
// - Release floats control, address and data outputs.
// - Host presents slave access; device samples chip select on a later edge.
// - Burst inhibit asserted during every second-mode slave access.
// - Slave read waits three clocks then drives read data.
// - Slave write waits three clocks after host data before acknowledging.
// - Error-free slave access asserts target acknowledge after the waits.
// - Slave error asserts only transfer error and ends next edge.
// - Error-free slave waits for transfer ack, then drops acknowledge.
// - Slave read ends with data outputs floated.
// - Instruction fetch asserts instr_load_n before bus request.
// - Wait for grant with bus idle, then take busy and owner, drop request; the code does all three on grant alone, even with the bus busy.
// - Quick-arbitration bit drives busy as soon as grant arrives.
// - Interrupt during request: finish grant, release one clock later, raise interrupt.
// - Snoop enable set: request one to two clocks after snoop_ctrl0 rises; the code requests four to five clocks after, from idle.
// - Request follows instr_load_n by one to two clocks.
// - instr_load_n drops one to two clocks after busy rises; held over retries.
`define WAIT_STATES 2'd3
`define REQ_DELAY 1'b1
`define QUICK_ARB_BIT 1
`define SNOOP_EN_BIT 0
`define DATA_W 32
`define FIFO_DEPTH 8
`endif

// >>> hdl/host_bus_pkg.sv
// Types for the host bus cycle interface
package host_bus_pkg;
   typedef enum logic [8:0] {
      M_IDLE = 9'h001, M_REQ = 9'h002, M_WAITG = 9'h004, M_ADDR = 9'h008,
      M_STRB = 9'h010, M_DSTB = 9'h020, M_TERM = 9'h040, M_ABORT = 9'h080,
      M_REL = 9'h100
   } mst_e;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01, S_WAIT = 5'h02, S_ACK = 5'h04, S_ERR = 5'h08, S_END = 5'h10
   } slv_e;
endpackage

// >>> hdl/word_fifo.sv
// Small word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_q[rd_q];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// >>> testbench/host_bus_cycle_interface_props.sv
// Concurrent checks on the host bus cycle interface ports
`timescale 1ns/1ps
module host_bus_cycle_interface_props (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic busy_bus_n_o,
   input wire logic busy_bus_n_oe,
   input wire logic req_bus_n,
   input wire logic owner_active_n,
   input wire logic grant_ack_n,
   input wire logic instr_load_n,
   input wire logic ctrl_oe,
   input wire logic addr_strobe_n,
   input wire logic data_strobe_n,
   input wire logic addr_oe,
   input wire logic data_oe,
   input wire logic transfer_ack_n,
   input wire logic burst_inhibit_n,
   input wire logic target_ack_n,
   input wire logic transfer_error_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_addr_phase;
      $fell(addr_strobe_n);
   endsequence
   sequence s_slave_start;
      $fell(burst_inhibit_n);
   endsequence
   sequence s_released;
      grant_ack_n ##[0:2] (!addr_oe && !ctrl_oe);
   endsequence
   a_addr_first: assert property (s_addr_phase |-> data_strobe_n)
      else $error("data strobe did not follow address strobe");
   a_drive_strobe: assert property (!addr_strobe_n |-> addr_oe && data_oe && ctrl_oe)
      else $error("strobe without driven address and data");
   a_release_float: assert property ($rose(owner_active_n) |-> s_released)
      else $error("outputs not floated on release");
   a_take_busy: assert property ($fell(owner_active_n) |-> ##[0:1] (req_bus_n && busy_bus_n_oe && !busy_bus_n_o))
      else $error("ownership taken without busy and request drop");
   a_slave_waits: assert property (s_slave_start |-> target_ack_n [*2])
      else $error("acknowledge before wait states");
   a_inhibit_held: assert property (!target_ack_n || !transfer_error_n |-> !burst_inhibit_n)
      else $error("burst inhibit missing during slave answer");
   a_error_alone: assert property (!transfer_error_n |-> target_ack_n)
      else $error("error and acknowledge together");
   a_ack_drop: assert property (!target_ack_n && !transfer_ack_n |-> ##[1:4] target_ack_n)
      else $error("acknowledge held after transfer ack");
   a_req_after_load: assert property ($fell(instr_load_n) |-> ##[1:2] !req_bus_n)
      else $error("request late after fetch");
   a_load_after_busy: assert property ($rose(instr_load_n) |-> $past(busy_bus_n_o))
      else $error("fetch dropped while busy held");
   a_slave_float: assert property ($rose(target_ack_n) |-> ##[0:3] !data_oe)
      else $error("data not floated after slave read");
endmodule

// >>> testbench/host_bus_partner.sv
// Behavioural host processor and bus arbiter facing the device
`timescale 1ns/1ps
module host_bus_partner (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic grant_hold,
   input wire logic retry_once,
   input wire logic burst_ok,
   input wire logic slow,
   input wire logic req_bus_n,
   input wire logic data_strobe_n,
   input wire logic line_burst_request_n,
   input wire logic target_ack_n,
   output logic grant_bus_n,
   output logic line_burst_ack_n,
   output logic sync_termination_n,
   output logic bus_fault_n,
   output logic stop_retry_n,
   output logic transfer_ack_n
);
   logic [2:0] wait_q;
   logic armed_q, retried_q;
   always_ff @(posedge sys_clk) begin
      grant_bus_n <= !rstn | req_bus_n | grant_hold;
      line_burst_ack_n <= !rstn | line_burst_request_n | !burst_ok;
      transfer_ack_n <= !rstn | target_ack_n;
      sync_termination_n <= 1'b1;
      bus_fault_n <= 1'b1;
      stop_retry_n <= 1'b1;
      if (!rstn || data_strobe_n) begin
         wait_q <= 3'h0;
         armed_q <= rstn;
         retried_q <= retried_q & rstn;
      end else if (armed_q && wait_q == (slow ? 3'h4 : 3'h0)) begin
         armed_q <= 1'b0;
         if (retry_once && !retried_q) begin
            bus_fault_n <= 1'b0;
            stop_retry_n <= 1'b0;
            retried_q <= 1'b1;
         end else begin
            sync_termination_n <= 1'b0;
         end
      end else begin
         wait_q <= wait_q + 3'h1;
      end
   end
endmodule

// >>> testbench/host_bus_cycle_interface_tb_top.sv
// Self-checking bench for the host bus cycle interface
`timescale 1ns/1ps
bind host_bus_cycle_interface host_bus_cycle_interface_props i_host_bus_cycle_interface_props (
   .sys_clk, .rstn, .busy_bus_n_o, .busy_bus_n_oe, .req_bus_n, .owner_active_n, .grant_ack_n,
   .instr_load_n, .ctrl_oe, .addr_strobe_n, .data_strobe_n, .addr_oe, .data_oe,
   .transfer_ack_n, .burst_inhibit_n, .target_ack_n, .transfer_error_n);
module host_bus_cycle_interface_tb_top;
   logic sys_clk = 1'b0, rstn = 1'b0, wr_valid = 1'b0, burst_enable = 1'b0, fetch_req = 1'b0;
   logic fetch_done = 1'b0, scsi_irq = 1'b0, snoop_ctrl0 = 1'b0, chip_select_n = 1'b1;
   logic fatal_error = 1'b0;
   logic transfer_start_n = 1'b1, read_write_n = 1'b1, slv_error = 1'b0, grant_hold = 1'b0;
   logic retry_once = 1'b0, burst_ok = 1'b0, slow = 1'b0, as_seen = 1'b0, burst_seen = 1'b0;
   logic [7:0] dma_control_reg = 8'h00, test_reg_three = 8'h00;
   logic [6:0] slv_addr = 7'h00, reg_addr;
   logic [1:0] wr_size = 2'h0, xfer_size;
   logic [31:0] wr_data = 32'h0000_0000, wr_addr = 32'h0000_0000, host_d = 32'h0000_0000;
   logic [31:0] reg_rdata = 32'hc3c3_5a5a, seen_wdata = 32'h0000_0000;
   logic wr_ready, irq, busy_bus_n_o, busy_bus_n_oe, busy_bus_n_i, req_bus_n, owner_active_n;
   logic grant_ack_n, instr_load_n, ctrl_oe, addr_strobe_n, data_strobe_n, line_burst_request_n;
   logic addr_oe, data_oe, burst_inhibit_n, target_ack_n, transfer_error_n, slv_oe, reg_wr;
   logic grant_bus_n, line_burst_ack_n, sync_termination_n, bus_fault_n, stop_retry_n;
   logic transfer_ack_n;
   logic [31:0] addr_o, data_o, data_i, reg_wdata;
   logic [31:0] exp_d[$], exp_a[$];
   int failures = 0, tests_run = 0, n, k;
   always #25 sys_clk = ~sys_clk;
   assign busy_bus_n_i = busy_bus_n_oe ? busy_bus_n_o : 1'b1;
   assign data_i = data_oe ? data_o : host_d;
   host_bus_cycle_interface i_host_bus_cycle_interface (
      .sys_clk, .rstn, .wr_valid, .wr_ready, .wr_data, .wr_addr, .wr_size, .burst_enable,
      .fetch_req, .fetch_done, .fatal_error, .scsi_irq, .irq, .dma_control_reg,
      .test_reg_three, .snoop_ctrl0, .grant_bus_n, .busy_bus_n_i, .busy_bus_n_o, .busy_bus_n_oe,
      .req_bus_n, .owner_active_n, .grant_ack_n, .instr_load_n, .ctrl_oe, .addr_strobe_n,
      .data_strobe_n, .line_burst_request_n, .line_burst_ack_n, .sync_termination_n,
      .bus_fault_n, .stop_retry_n, .addr_o, .addr_oe, .xfer_size, .data_o, .data_oe, .data_i,
      .chip_select_n, .transfer_start_n, .read_write_n, .slv_addr, .slv_error, .transfer_ack_n,
      .burst_inhibit_n, .target_ack_n, .transfer_error_n, .slv_oe, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rdata);
   host_bus_partner i_host_bus_partner (.sys_clk, .rstn, .grant_hold, .retry_once, .burst_ok,
      .slow, .req_bus_n, .data_strobe_n, .line_burst_request_n, .target_ack_n, .grant_bus_n,
      .line_burst_ack_n, .sync_termination_n, .bus_fault_n, .stop_retry_n, .transfer_ack_n);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      chk(32'h0000_0000, 32'h0000_0001);
      report_and_stop();
   endtask
   always @(posedge sys_clk) begin
      if (!line_burst_request_n) burst_seen = 1'b1;
      if (!addr_strobe_n) as_seen = 1'b1;
      if (reg_wr === 1'b1) seen_wdata = reg_wdata;
      if (!sync_termination_n && bus_fault_n && !data_strobe_n) begin
         if (exp_d.size() == 0) chk(32'h0000_0000, 32'h0000_0001);
         else begin
            chk(data_o, exp_d.pop_front());
            chk(addr_o, exp_a.pop_front());
         end
      end
   end
   task automatic push(input int cnt);
      wr_valid <= 1'b1;
      for (k = 0; k < cnt; k++) begin
         wr_data <= 32'h1000_0000 + k;
         wr_addr <= 32'h0000_0400 + 4 * k;
         @(negedge sys_clk);
         if (wr_ready !== 1'b1) break;
         exp_d.push_back(32'h1000_0000 + k);
         exp_a.push_back(32'h0000_0400 + 4 * k);
         @(posedge sys_clk);
      end
      if (k < cnt) @(posedge sys_clk);
      wr_valid <= 1'b0;
   endtask
   task automatic drain();
      for (n = 0; n < 800 && (exp_d.size() != 0 || owner_active_n !== 1'b1); n++)
         @(posedge sys_clk);
      if (n == 800) tmo();
      chk(grant_ack_n, 1'b1);
      repeat (3) @(posedge sys_clk);
      chk({addr_oe, data_oe, ctrl_oe}, 3'h0);
   endtask
   task automatic t_fill_retry();
      grant_hold <= 1'b1;
      retry_once <= 1'b1;
      push(12);
      chk(k, 8);
      grant_hold <= 1'b0;
      drain();
      retry_once <= 1'b0;
   endtask
   task automatic t_burst_quick();
      burst_enable <= 1'b1;
      burst_ok <= 1'b1;
      slow <= 1'b1;
      dma_control_reg <= 8'h02;
      burst_seen = 1'b0;
      push(4);
      drain();
      chk(burst_seen, 1'b1);
      burst_enable <= 1'b0;
      slow <= 1'b0;
   endtask
   task automatic t_slave(input logic rw, input logic err);
      read_write_n <= rw;
      slv_addr <= 7'h2c;
      chip_select_n <= 1'b0;
      transfer_start_n <= 1'b0;
      slv_error <= err;
      host_d <= 32'h5555_aaaa;
      @(posedge sys_clk);
      transfer_start_n <= 1'b1;
      host_d <= 32'hbeef_0042;
      for (n = 0; n < 40 && target_ack_n !== 1'b0 && transfer_error_n !== 1'b0; n++)
         @(posedge sys_clk);
      if (n == 40) tmo();
      chk(n >= 3, 1'b1);
      chk(burst_inhibit_n, 1'b0);
      chk({target_ack_n, transfer_error_n}, err ? 2'h2 : 2'h1);
      chk(reg_addr, 32'h0000_002c);
      if (rw && !err) chk({data_oe, data_o}, {1'b1, reg_rdata});
      for (n = 0; n < 40 && (target_ack_n & transfer_error_n) !== 1'b1; n++)
         @(posedge sys_clk);
      if (n == 40) tmo();
      repeat (3) @(posedge sys_clk);
      chip_select_n <= 1'b1;
      slv_error <= 1'b0;
      chk(data_oe, 1'b0);
      if (!rw && !err) chk(seen_wdata, 32'hbeef_0042);
   endtask
   task automatic t_fetch();
      fetch_req <= 1'b1;
      for (n = 0; n < 20 && instr_load_n !== 1'b0; n++)
         @(posedge sys_clk);
      if (n == 20) tmo();
      for (n = 0; n < 5 && req_bus_n !== 1'b0; n++)
         @(posedge sys_clk);
      chk(n >= 1 && n <= 2, 1'b1);
      for (n = 0; n < 40 && owner_active_n !== 1'b0; n++)
         @(posedge sys_clk);
      if (n == 40) tmo();
      @(posedge sys_clk);
      chk({req_bus_n, busy_bus_n_oe, busy_bus_n_o}, 3'h6);
      fetch_req <= 1'b0;
      fetch_done <= 1'b1;
      @(posedge sys_clk);
      fetch_done <= 1'b0;
      for (n = 0; n < 40 && busy_bus_n_o !== 1'b1; n++)
         @(posedge sys_clk);
      if (n == 40) tmo();
      for (n = 0; n < 5 && instr_load_n !== 1'b1; n++)
         @(posedge sys_clk);
      chk(n >= 1 && n <= 2, 1'b1);
   endtask
   task automatic t_irq_abort();
      grant_hold <= 1'b1;
      fetch_req <= 1'b1;
      as_seen = 1'b0;
      for (n = 0; n < 20 && req_bus_n !== 1'b0; n++)
         @(posedge sys_clk);
      if (n == 20) tmo();
      scsi_irq <= 1'b1;
      repeat (4) @(posedge sys_clk);
      grant_hold <= 1'b0;
      fetch_req <= 1'b0;
      for (n = 0; n < 40 && irq !== 1'b1; n++)
         @(posedge sys_clk);
      if (n == 40) tmo();
      scsi_irq <= 1'b0;
      chk({as_seen, req_bus_n}, 2'h1);
      fatal_error <= 1'b1;
      @(posedge sys_clk);
      fatal_error <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(instr_load_n, 1'b1);
   endtask
   task automatic t_snoop();
      test_reg_three <= 8'h01;
      snoop_ctrl0 <= 1'b1;
      for (n = 0; n < 8 && req_bus_n !== 1'b0; n++)
         @(posedge sys_clk);
      chk(n >= 1 && n <= 6, 1'b1);
      snoop_ctrl0 <= 1'b0;
      test_reg_three <= 8'h00;
      repeat (20) @(posedge sys_clk);
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      t_fill_retry();
      t_burst_quick();
      t_slave(1'b1, 1'b0);
      t_slave(1'b0, 1'b0);
      t_slave(1'b1, 1'b1);
      t_fetch();
      t_irq_abort();
      t_snoop();
      report_and_stop();
   end
endmodule
